// ---- core/asrp_map.vh ----
// Frame layout, field positions, reset values and codes of the converter control block.
`ifndef ASRP_MAP_VH
`define ASRP_MAP_VH
// ============================================================
// Frame layout
`define ASRP_FRAME_BITS 16
`define ASRP_POS_WRITE 15
`define ASRP_POS_SEL1 14
`define ASRP_POS_SEL2 13
`define ASRP_SEL_CONFIG 2'b00
`define ASRP_SEL_SPAN 2'b01
`define ASRP_SEL_LIST 2'b11
`define ASRP_PD_EDGE 15
// ============================================================
// Configuration word fields
`define ASRP_CFG_ADDR_HI 11
`define ASRP_CFG_ADDR_LO 10
`define ASRP_CFG_MODE_HI 9
`define ASRP_CFG_MODE_LO 8
`define ASRP_CFG_PM_HI 7
`define ASRP_CFG_PM_LO 6
`define ASRP_CFG_CODING 5
`define ASRP_CFG_REF 4
`define ASRP_CFG_SEQ_HI 3
`define ASRP_CFG_SEQ_LO 2
// ============================================================
// Reset values
`define ASRP_CFG_RESET 12'h000
`define ASRP_SPAN_RESET 8'h00
`define ASRP_LIST_RESET 4'h0
// ============================================================
// Codes
`define ASRP_PM_NORMAL 2'b00
`define ASRP_PM_STANDBY 2'b01
`define ASRP_PM_AUTOSHUT 2'b10
`define ASRP_PM_FULLSHUT 2'b11
`define ASRP_SEQ_LIST 2'b01
`define ASRP_SEQ_CONSEC 2'b10
`define ASRP_SPAN_10V 2'b00
`define ASRP_SPAN_5V 2'b01
`define ASRP_SPAN_2V5 2'b10
`define ASRP_SPAN_UNI10 2'b11
`endif

// ---- core/asrp_sync.v ----
// Two-flop synchroniser with edge pulses for the serial pins.
`timescale 1ns/1ps
`default_nettype none
module asrp_sync (
    input wire clk,
    input wire rst_n,
    input wire din,
    output wire level,
    output wire rise,
    output wire fall
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    // ============================================================
    // The second and third flops feed the edge detector.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign level = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

// ---- core/asrp_span_decode.v ----
// Decoder of a two-bit span code into one-hot span selects.
`timescale 1ns/1ps
`default_nettype none
`include "asrp_map.vh"
module asrp_span_decode (
    input wire [1:0] code,
    output reg [3:0] span_onehot
);
    // ============================================================
    // Bit 0: +-10 V, bit 1: +-5 V, bit 2: +-2.5 V, bit 3: 0 V to +10 V.
    always @* begin
        case (code)
            `ASRP_SPAN_10V: span_onehot = 4'h1;
            `ASRP_SPAN_5V: span_onehot = 4'h2;
            `ASRP_SPAN_2V5: span_onehot = 4'h4;
            default: span_onehot = 4'h8;
        endcase
    end
endmodule
`default_nettype wire

// ---- core/asrp_ctrl.v ----
// Configuration, power-mode and channel sequencer logic of the converter.
// Contract
// - Both power bits set: everything off, configuration word kept.
// - Power bits 10: automatic shutdown at the 15th shift clock rise.
// - Power bits 01: standby at the 15th rise, reference stays on.
// - Power bits 00: everything stays powered.
// - Sequencer bits 00 or 11: convert channel named by address bits.
// - Sequencer 01: listed channels, lowest first, ascending, wrapping.
// - Each sequenced channel uses its latest written span.
// - Sequencer 10: channels 0 to address bits, list ignored.
// - Channel list is a 4-bit write-only store, 1 includes channel.
// - Span store is 8 bits, two per channel, channel 0 highest.
// - Span store loads only for write bit 1 and select 01.
// - Span codes: 00 10V, 01 5V, 10 2.5V, 11 unipolar 10V.
// - After reset all spans are +-10 V and all stores default.
// - A selected channel is configured with its stored span.
// - List sequence runs on until a configuration or list word is written.
// - Span change needs stop 00, span write, restart 01 from first.
// - Consecutive mode survives idle frames; 00 write ends it.
// - Header: write 0 ignores; 00 config, 01 span, 11 list.
// - Configuration word resets to zero: normal power, traditional.
// - Auto modes wake at chip-select rise, sleep at 15th rise.
`timescale 1ns/1ps
`default_nettype none
`include "asrp_map.vh"
module asrp_ctrl (
    input wire CLK,
    input wire RSTN,
    input wire SCLK,
    input wire CS_N,
    input wire DIN,
    output reg [1:0] CHANNEL,
    output wire [1:0] SPAN_CODE,
    output wire [3:0] SPAN_SEL,
    output reg POWER_DOWN,
    output reg REF_POWER_DOWN,
    output wire [1:0] INPUT_MODE,
    output wire CODING,
    output wire REF_INTERNAL,
    output reg FRAME_DONE
);
    localparam ST_IDLE = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_DONE = 3'b100;

    wire sclk_rise;
    wire sclk_fall;
    wire cs_lvl;
    wire cs_rise;
    wire cs_fall;
    wire din_lvl;
    reg [2:0] st_q;
    reg [4:0] bit_cnt_q;
    reg [15:0] shift_q;
    reg [11:0] cfg_q;
    reg [7:0] span_q;
    reg [3:0] list_q;
    reg [1:0] ptr_q;
    reg seq_restart_q;
    reg asleep_q;
    reg [15:0] frame_d;
    reg [1:0] ptr_d;
    reg [1:0] chan_d;
    reg restart_d;
    reg pd_d;
    reg ref_pd_d;
    reg asleep_d;
    wire cfg_wr;
    wire span_wr;
    wire list_wr;
    wire [1:0] pm;
    wire [1:0] seq;
    wire [1:0] addr;
    wire list_mode;
    wire consec_mode;
    wire hdr_write;
    wire [1:0] hdr_sel;

    // ============================================================
    // Pin synchronisers
    asrp_sync u_sync_sclk (
        .clk(CLK),
        .rst_n(RSTN),
        .din(SCLK),
        .level(),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );
    asrp_sync u_sync_cs (
        .clk(CLK),
        .rst_n(RSTN),
        .din(CS_N),
        .level(cs_lvl),
        .rise(cs_rise),
        .fall(cs_fall)
    );
    asrp_sync u_sync_din (
        .clk(CLK),
        .rst_n(RSTN),
        .din(DIN),
        .level(din_lvl),
        .rise(),
        .fall()
    );

    // ============================================================
    // Functions
    // Lowest flagged channel at or above start, wrapping; start if none.
    function [1:0] next_listed;
        input [3:0] list;
        input [1:0] start;
        integer i;
        reg found;
        reg [1:0] idx;
        begin
            found = 1'b0;
            next_listed = start;
            for (i = 0; i < 4; i = i + 1) begin
                idx = start + i[1:0];
                if (!found && list[idx]) begin
                    found = 1'b1;
                    next_listed = idx;
                end
            end
        end
    endfunction

    // Write strobe of one store, raised for the frame just completed.
    function hdr_hits;
        input done;
        input write;
        input [1:0] sel;
        input [1:0] target;
        begin
            hdr_hits = done & write & (sel == target);
        end
    endfunction

    // Span code of a channel, channel 0 in the top pair.
    function [1:0] span_of;
        input [7:0] span;
        input [1:0] ch;
        begin
            case (ch)
                2'd0: span_of = span[7:6];
                2'd1: span_of = span[5:4];
                2'd2: span_of = span[3:2];
                default: span_of = span[1:0];
            endcase
        end
    endfunction

    assign pm = {cfg_q[`ASRP_CFG_PM_HI], cfg_q[`ASRP_CFG_PM_LO]};
    assign seq = {cfg_q[`ASRP_CFG_SEQ_HI], cfg_q[`ASRP_CFG_SEQ_LO]};
    assign addr = {cfg_q[`ASRP_CFG_ADDR_HI], cfg_q[`ASRP_CFG_ADDR_LO]};
    assign list_mode = (seq == `ASRP_SEQ_LIST);
    assign consec_mode = (seq == `ASRP_SEQ_CONSEC);
    assign INPUT_MODE = {cfg_q[`ASRP_CFG_MODE_HI], cfg_q[`ASRP_CFG_MODE_LO]};
    assign CODING = cfg_q[`ASRP_CFG_CODING];
    assign REF_INTERNAL = cfg_q[`ASRP_CFG_REF];
    assign hdr_write = shift_q[`ASRP_POS_WRITE];
    assign hdr_sel = {shift_q[`ASRP_POS_SEL1], shift_q[`ASRP_POS_SEL2]};
    assign cfg_wr = hdr_hits(FRAME_DONE, hdr_write, hdr_sel, `ASRP_SEL_CONFIG);
    assign span_wr = hdr_hits(FRAME_DONE, hdr_write, hdr_sel, `ASRP_SEL_SPAN);
    assign list_wr = hdr_hits(FRAME_DONE, hdr_write, hdr_sel, `ASRP_SEL_LIST);

    // ============================================================
    // Frame receiver
    // Data is sampled on the falling shift clock edge, as the host
    // changes it with the rising one.
    always @* begin
        frame_d = {shift_q[14:0], din_lvl};
    end

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= ST_IDLE;
            bit_cnt_q <= 5'd0;
            shift_q <= 16'h0000;
            FRAME_DONE <= 1'b0;
        end else begin
            FRAME_DONE <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (cs_fall) begin
                        st_q <= ST_SHIFT;
                        bit_cnt_q <= 5'd0;
                    end
                end
                ST_SHIFT: begin
                    if (cs_lvl) begin
                        // A short frame writes no store, though a 15th shift clock rise in it still applies the power bits.
                        st_q <= ST_IDLE;
                    end else if (sclk_fall) begin
                        shift_q <= frame_d;
                        bit_cnt_q <= bit_cnt_q + 5'd1;
                        if (bit_cnt_q == 5'd15) begin
                            st_q <= ST_DONE;
                            FRAME_DONE <= 1'b1;
                        end
                    end
                end
                ST_DONE: begin
                    if (cs_lvl) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // Register stores
    // The stores are write-only, so nothing reads them back; a refused header
    // leaves all three untouched.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q <= `ASRP_CFG_RESET;
            span_q <= `ASRP_SPAN_RESET;
            list_q <= `ASRP_LIST_RESET;
        end else begin
            if (cfg_wr) begin
                cfg_q <= shift_q[11:0];
            end
            if (span_wr) begin
                span_q <= shift_q[12:5];
            end
            if (list_wr) begin
                // Channel 0 arrives first, so the flags are turned round to
                // let bit n of the store flag channel n.
                list_q <= {shift_q[9], shift_q[10], shift_q[11], shift_q[12]};
            end
        end
    end

    // ============================================================
    // Channel sequencer
    // A configuration or list write restarts the run at its first channel;
    // a span write does not, so spans can be changed between stop and restart.
    // The restart is taken one cycle after the write, when the new mode bits
    // are in place, and is then dropped so that later frames advance the run.
    always @* begin
        restart_d = seq_restart_q;
        ptr_d = ptr_q;
        chan_d = CHANNEL;
        if (cfg_wr || list_wr) begin
            restart_d = 1'b1;
        end else if (seq_restart_q) begin
            restart_d = 1'b0;
        end
        if (list_mode) begin
            if (seq_restart_q) begin
                ptr_d = next_listed(list_q, 2'd0);
            end else if (FRAME_DONE) begin
                ptr_d = next_listed(list_q, ptr_q + 2'd1);
            end
            chan_d = ptr_q;
        end else if (consec_mode) begin
            if (seq_restart_q) begin
                ptr_d = 2'd0;
            end else if (FRAME_DONE) begin
                // Idle frames keep the run going.
                ptr_d = (ptr_q >= addr) ? 2'd0 : ptr_q + 2'd1;
            end
            chan_d = ptr_q;
        end else begin
            ptr_d = 2'd0;
            chan_d = addr;
        end
    end

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ptr_q <= 2'd0;
            seq_restart_q <= 1'b1;
            CHANNEL <= 2'd0;
        end else begin
            ptr_q <= ptr_d;
            seq_restart_q <= restart_d;
            CHANNEL <= chan_d;
        end
    end

    assign SPAN_CODE = span_of(span_q, CHANNEL);

    asrp_span_decode u_span (
        .code(SPAN_CODE),
        .span_onehot(SPAN_SEL)
    );

    // ============================================================
    // Power control
    // Changes take effect at the 15th rising shift clock edge of a frame, using
    // the power bits already held, so a new setting acts from the next frame.
    // Full shutdown is never left at chip-select rise, only by new power bits.
    always @* begin
        pd_d = POWER_DOWN;
        ref_pd_d = REF_POWER_DOWN;
        asleep_d = asleep_q;
        if (st_q == ST_SHIFT && sclk_rise && bit_cnt_q == 5'd14) begin
            case (pm)
                `ASRP_PM_FULLSHUT: begin
                    pd_d = 1'b1;
                    ref_pd_d = 1'b1;
                    asleep_d = 1'b0;
                end
                `ASRP_PM_AUTOSHUT: begin
                    pd_d = 1'b1;
                    ref_pd_d = 1'b1;
                    asleep_d = 1'b1;
                end
                `ASRP_PM_STANDBY: begin
                    pd_d = 1'b1;
                    ref_pd_d = 1'b0;
                    asleep_d = 1'b1;
                end
                default: begin
                    pd_d = 1'b0;
                    ref_pd_d = 1'b0;
                    asleep_d = 1'b0;
                end
            endcase
        end else if (cs_rise && asleep_q) begin
            pd_d = 1'b0;
            ref_pd_d = 1'b0;
            asleep_d = 1'b0;
        end
    end

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            POWER_DOWN <= 1'b0;
            REF_POWER_DOWN <= 1'b0;
            asleep_q <= 1'b0;
        end else begin
            POWER_DOWN <= pd_d;
            REF_POWER_DOWN <= ref_pd_d;
            asleep_q <= asleep_d;
        end
    end
endmodule
`default_nettype wire

// ---- dv/asrp_monitor.sv ----
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module asrp_monitor (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic [1:0] CHANNEL,
    input wire logic [1:0] SPAN_CODE,
    input wire logic [3:0] SPAN_SEL,
    input wire logic POWER_DOWN,
    input wire logic REF_POWER_DOWN,
    input wire logic [1:0] INPUT_MODE,
    input wire logic FRAME_DONE
);
    // ============================================================
    // Sequences
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_done;
        FRAME_DONE ##1 !FRAME_DONE;
    endsequence
    // Stores and the pointer may only move in the few cycles after a frame ends.
    sequence s_recent;
        $past(FRAME_DONE) || $past(FRAME_DONE, 2) || $past(FRAME_DONE, 3);
    endsequence
    // ============================================================
    // Properties
    property p_done; $rose(FRAME_DONE) |-> s_done; endproperty
    a_done: assert property (p_done) else $error("frame done longer than one cycle");
    property p_chan; $changed(CHANNEL) |-> s_recent; endproperty
    a_chan: assert property (p_chan) else $error("channel moved outside a frame end");
    property p_mode; $changed(INPUT_MODE) |-> s_recent; endproperty
    a_mode: assert property (p_mode) else $error("input mode moved outside a frame end");
    property p_span; $changed(SPAN_CODE) |-> s_recent; endproperty
    a_span: assert property (p_span) else $error("span code moved outside a frame end");
    property p_sel; SPAN_SEL == (4'h1 << SPAN_CODE); endproperty
    a_sel: assert property (p_sel) else $error("span select does not match code");
    property p_ref; REF_POWER_DOWN |-> POWER_DOWN; endproperty
    a_ref: assert property (p_ref) else $error("reference down while core up");
    property p_pdrise; $rose(POWER_DOWN) |-> !CS_N; endproperty
    a_pdrise: assert property (p_pdrise) else $error("power down outside a frame");
    property p_pdwin; $changed(POWER_DOWN) |-> !CS_N || !$past(CS_N, 6); endproperty
    a_pdwin: assert property (p_pdwin) else $error("power state moved while idle");
    property p_rst;
        $rose(RSTN) |-> CHANNEL == 2'b00 && !POWER_DOWN && SPAN_SEL == 4'h1 && INPUT_MODE == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset values");
endmodule
bind asrp_ctrl asrp_monitor i_asrp_monitor (.CLK, .RSTN, .CS_N, .CHANNEL, .SPAN_CODE,
    .SPAN_SEL, .POWER_DOWN, .REF_POWER_DOWN, .INPUT_MODE, .FRAME_DONE);
`default_nettype wire

// ---- dv/asrp_host.sv ----
// Host model that sends serial configuration frames.
`timescale 1ns/1ps
`default_nettype none
module asrp_host (
    output var logic SCLK,
    output var logic CS_N,
    output var logic DIN
);
    // ============================================================
    // Frame sender
    // The shift clock rests between frames and released data is inverted,
    // so a design that samples outside a frame sees a wrong bit.
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DIN = 1'b1;
    end
    task automatic send(input logic [15:0] w);
        integer i;
        CS_N = 1'b0;
        #200;
        for (i = 15; i >= 0; i = i - 1) begin
            DIN = w[i];
            SCLK = 1'b1;
            #200;
            SCLK = 1'b0;
            #200;
        end
        CS_N = 1'b1;
        DIN = ~DIN;
        #600;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic CLK, RSTN, SCLK, CS_N, DIN;
    logic [1:0] CHANNEL, SPAN_CODE, INPUT_MODE;
    logic [3:0] SPAN_SEL;
    logic POWER_DOWN, REF_POWER_DOWN, CODING, REF_INTERNAL, FRAME_DONE;
    logic pd_seen, rpd_seen;
    integer bad_count = 0;
    integer comparisons = 0;
    asrp_ctrl i_asrp_ctrl (.CLK, .RSTN, .SCLK, .CS_N, .DIN, .CHANNEL, .SPAN_CODE, .SPAN_SEL,
        .POWER_DOWN, .REF_POWER_DOWN, .INPUT_MODE, .CODING, .REF_INTERNAL, .FRAME_DONE);
    asrp_host i_asrp_host (.SCLK, .CS_N, .DIN);
    // ============================================================
    // Clock and helpers
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // Power state is caught at frame end, after the 15th shift edge.
    always @(posedge CLK) begin
        if (FRAME_DONE) begin
            pd_seen <= POWER_DOWN;
            rpd_seen <= REF_POWER_DOWN;
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [15:0] cfg(input logic [1:0] a, pm, sq);
        return {4'h8, a, 2'b10, pm, 2'b10, sq, 2'b00};
    endfunction
    task automatic tx(input logic [15:0] w);
        i_asrp_host.send(w);
        repeat (4) @(posedge CLK);
        #1;
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset;
        chk("channel", 8'h0, CHANNEL);
        chk("span_sel", 8'h1, SPAN_SEL);
        chk("power", 8'h0, {POWER_DOWN, REF_POWER_DOWN});
        chk("mode", 8'h0, {INPUT_MODE, CODING, REF_INTERNAL});
    endtask
    task automatic t_trad;
        tx(cfg(2'd2, 2'b00, 2'b00));
        chk("channel", 8'h2, CHANNEL);
        chk("mode", 8'h5, {INPUT_MODE, CODING});
        tx(16'h7c00);
        chk("ignored", 8'h2, CHANNEL);
        tx(cfg(2'd1, 2'b00, 2'b11));
        chk("channel", 8'h1, CHANNEL);
        tx(16'h8110);
        chk("mode_ref", 8'h5, {INPUT_MODE, CODING, REF_INTERNAL});
    endtask
    task automatic t_span;
        integer c;
        tx({3'b101, 8'h1b, 5'h00});
        for (c = 0; c < 4; c = c + 1) begin
            tx(cfg(c[1:0], 2'b00, 2'b00));
            chk("span_code", c[7:0], SPAN_CODE);
            chk("span_sel", 8'h1 << c, SPAN_SEL);
        end
        tx(16'hdfe0);
        tx(cfg(2'd0, 2'b00, 2'b00));
        chk("span_refused", 8'h0, SPAN_CODE);
    endtask
    task automatic t_list;
        integer k;
        tx({3'b111, 4'b0101, 9'h000});
        tx(cfg(2'd0, 2'b00, 2'b01));
        for (k = 0; k < 4; k = k + 1) begin
            chk("list_channel", k[0] ? 8'h3 : 8'h1, CHANNEL);
            chk("list_span", k[0] ? 8'h3 : 8'h1, SPAN_CODE);
            tx(16'h0000);
        end
        tx(cfg(2'd0, 2'b00, 2'b00));
        tx({3'b101, 8'h30, 5'h00});
        tx(cfg(2'd2, 2'b00, 2'b01));
        chk("restart", 8'h1, CHANNEL);
        chk("new_span", 8'h3, SPAN_CODE);
    endtask
    task automatic t_consec;
        integer k;
        tx(cfg(2'd2, 2'b00, 2'b10));
        for (k = 0; k < 5; k = k + 1) begin
            chk("consec", 8'(k % 3), CHANNEL);
            tx(k[0] ? 16'h0000 : 16'h1fff);
        end
        tx(cfg(2'd3, 2'b00, 2'b00));
        chk("traditional", 8'h3, CHANNEL);
    endtask
    task automatic t_power;
        tx(cfg(2'd0, 2'b10, 2'b00));
        tx(16'h0000);
        chk("autoshut_in", 8'h3, {pd_seen, rpd_seen});
        chk("autoshut_out", 8'h0, {POWER_DOWN, REF_POWER_DOWN});
        tx(cfg(2'd0, 2'b01, 2'b00));
        tx(16'h0000);
        chk("standby_in", 8'h2, {pd_seen, rpd_seen});
        chk("standby_out", 8'h0, {POWER_DOWN, REF_POWER_DOWN});
        tx(cfg(2'd1, 2'b11, 2'b00));
        tx(16'h0000);
        chk("full", 8'h3, {POWER_DOWN, REF_POWER_DOWN});
        chk("kept", 8'h5, {INPUT_MODE, CODING});
        tx(cfg(2'd0, 2'b00, 2'b00));
        tx(16'h0000);
        chk("normal", 8'h0, {pd_seen, POWER_DOWN});
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ============================================================
    // Main sequence and watchdog
    initial begin
        RSTN = 1'b0;
        repeat (12) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        #1;
        t_reset();
        t_trad();
        t_span();
        t_list();
        t_consec();
        t_power();
        @(posedge CLK) RSTN <= 1'b0;
        repeat (3) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        #1;
        t_reset();
        report_and_stop();
    end
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        report_and_stop();
    end
endmodule
`default_nettype wire
